// ===== design/ccie_channel_enable.sv
// one channel's enable flip-flop, decoded from its two-bit command field
// assumes the write strobe is a single-cycle pulse on sys_clk
`timescale 1ns/1ps
module ccie_channel_enable
    import ccie_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // command
    input  wire logic       wrEnable,
    input  wire logic [1:0] cmdField,
    // state
    output logic            enableReg
);

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            enableReg <= CCIE_ENABLE_RESET[0];
        else if (wrEnable && cmdField == CCIE_CMD_SET)
            enableReg <= 1'b1;
        else if (wrEnable && cmdField == CCIE_CMD_CLEAR)
            enableReg <= 1'b0;
        // other codes leave the enable as it is
    end

endmodule

// ===== design/ccie_pkg.sv
// package for the per-channel CAN interrupt enable block
// assumes an 8-bit host bus with byte-wide register offsets
package ccie_pkg;

    localparam int          CCIE_CHANNELS      = 4;
    localparam int          CCIE_FIELD_W       = 2;
    localparam int          CCIE_ADDR_W        = 4;
    localparam int          CCIE_DATA_W        = 8;

    // offsets of channel_irq_enable_control and of the read-only pending register
    localparam logic [3:0]  CCIE_OFF_ENABLE    = 4'h7;
    localparam logic [3:0]  CCIE_OFF_PENDING   = 4'h8;

    // write command codes and read state codes of a channel field
    localparam logic [1:0]  CCIE_CMD_CLEAR     = 2'h2;
    localparam logic [1:0]  CCIE_CMD_SET       = 2'h3;
    localparam logic [1:0]  CCIE_STATE_ON      = 2'h1;
    localparam logic [1:0]  CCIE_STATE_OFF     = 2'h0;

    localparam logic [3:0]  CCIE_ENABLE_RESET  = 4'h0;
    localparam logic [7:0]  CCIE_READ_UNMAPPED = 8'h00;

    // divider value that software programs into each controller
    localparam logic [7:0]  CCIE_DIV_LEGACY    = 8'h07;
    localparam logic [7:0]  CCIE_DIV_EXTENDED  = 8'h87;

    typedef struct packed {
        logic             wrStb;
        logic             rdStb;
        logic [3:0]       addr;
        logic [7:0]       wrData;
    } ccie_bus_req_t;

    typedef struct packed {
        logic             rdValid;
        logic [7:0]       rdData;
    } ccie_bus_rsp_t;

endpackage

// ===== design/ccie_top.sv
// per-channel interrupt enable and pending registers for four CAN controllers
// assumes single-cycle host strobes on sys_clk and raw controller request pins
`timescale 1ns/1ps
module ccie_top
    import ccie_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    // host register port
    input  wire ccie_bus_req_t busReq,
    output ccie_bus_rsp_t      busRsp,
    // controller interrupt requests, active high after board inversion
    input  wire logic [3:0]    canIrqPin,
    // host interrupt line
    output logic               hostIrq
);

    logic [3:0] irqSync1Reg;
    logic [3:0] irqSync2Reg;
    logic [3:0] enableState;
    logic       wrEnableHit;

    // requests come from other chips, so synchronise before use
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqSync1Reg <= 4'h0;
            irqSync2Reg <= 4'h0;
        end
        else
        begin
            irqSync1Reg <= canIrqPin;
            irqSync2Reg <= irqSync1Reg;
        end
    end

    // writes to any other offset, the read-only pending one included, are dropped
    assign wrEnableHit = busReq.wrStb && busReq.addr == CCIE_OFF_ENABLE;

    genvar ch;
    generate
        for (ch = 0; ch < CCIE_CHANNELS; ch++)
        begin : g_chan
            ccie_channel_enable u_en (
                .sys_clk   (sys_clk),
                .sys_rst   (sys_rst),
                .wrEnable  (wrEnableHit),
                .cmdField  (busReq.wrData[ch*CCIE_FIELD_W +: CCIE_FIELD_W]),
                .enableReg (enableState[ch])
            );
        end
    endgenerate

    // read data registered one cycle after the strobe
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busRsp.rdValid <= 1'b0;
            busRsp.rdData  <= CCIE_READ_UNMAPPED;
        end
        else
        begin
            busRsp.rdValid <= busReq.rdStb;
            if (busReq.rdStb)
            begin
                case (busReq.addr)
                    CCIE_OFF_ENABLE:
                        for (int i = 0; i < CCIE_CHANNELS; i++)
                            busRsp.rdData[i*CCIE_FIELD_W +: CCIE_FIELD_W] <=
                                enableState[i] ? CCIE_STATE_ON : CCIE_STATE_OFF;
                    CCIE_OFF_PENDING:
                        busRsp.rdData <= {4'h0, irqSync2Reg};
                    default:
                        busRsp.rdData <= CCIE_READ_UNMAPPED;
                endcase
            end
        end
    end

    // a disabled channel can never reach the line
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            hostIrq <= 1'b0;
        else
            hostIrq <= |(irqSync2Reg & enableState);
    end

    // is software's duty; constants CCIE_DIV_* name the values it must use.

    a_set_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[1:0] == CCIE_CMD_SET |=> enableState[0])
        else $error("channel one enable not set");

    a_clear_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[7:6] == CCIE_CMD_CLEAR |=> !enableState[3])
        else $error("channel four enable not cleared");

    a_ignore_cmd: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && !busReq.wrData[3] |=> $stable(enableState[1]))
        else $error("ignored command changed channel two");

    a_read_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.rdStb && busReq.addr == CCIE_OFF_ENABLE |=>
        busRsp.rdValid && busRsp.rdData == {1'b0, $past(enableState[3]),
        1'b0, $past(enableState[2]), 1'b0, $past(enableState[1]),
        1'b0, $past(enableState[0])})
        else $error("enable read data wrong");

    a_field_place: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[5:4] == CCIE_CMD_SET |=> enableState[2])
        else $error("channel three field misplaced");

    a_pending_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.rdStb && busReq.addr == CCIE_OFF_PENDING |=>
        busRsp.rdData == {4'h0, $past(canIrqPin, 3)})
        else $error("pending read wrong");

    a_irq_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 hostIrq == |($past(irqSync2Reg) & $past(enableState)))
        else $error("host interrupt not gated by enables");

    a_irq_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
        enableState == 4'h0 ##1 enableState == 4'h0 |-> !hostIrq)
        else $error("interrupt with all channels disabled");

    // each field decodes on its own, so every channel is watched separately
    a_set_chan_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[3:2] == CCIE_CMD_SET |=> enableState[1])
        else $error("channel two enable not set");

    a_set_chan_four: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[7:6] == CCIE_CMD_SET |=> enableState[3])
        else $error("channel four enable not set");

    a_clear_chan_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[1:0] == CCIE_CMD_CLEAR |=> !enableState[0])
        else $error("channel one enable not cleared");

    a_clear_chan_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[3:2] == CCIE_CMD_CLEAR |=> !enableState[1])
        else $error("channel two enable not cleared");

    a_clear_chan_three: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[5:4] == CCIE_CMD_CLEAR |=> !enableState[2])
        else $error("channel three enable not cleared");

    a_ignore_chan_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && !busReq.wrData[1] |=> $stable(enableState[0]))
        else $error("ignored command changed channel one");

    a_ignore_chan_three: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && !busReq.wrData[5] |=> $stable(enableState[2]))
        else $error("ignored command changed channel three");

    a_ignore_chan_four: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && !busReq.wrData[7] |=> $stable(enableState[3]))
        else $error("ignored command changed channel four");

    // enables move only on a write that hits their own register
    a_hold_no_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !wrEnableHit |=> $stable(enableState))
        else $error("enable changed without a write");

    a_offset_write_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.wrStb && busReq.addr != CCIE_OFF_ENABLE |=> $stable(enableState))
        else $error("write to another offset changed an enable");

    a_read_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 busRsp.rdValid == $past(busReq.rdStb))
        else $error("read valid not one cycle after strobe");

    a_read_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !busReq.rdStb |=> $stable(busRsp.rdData))
        else $error("read data moved without a read");

    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.rdStb && busReq.addr != CCIE_OFF_ENABLE && busReq.addr != CCIE_OFF_PENDING
        |=> busRsp.rdData == CCIE_READ_UNMAPPED)
        else $error("unmapped read not zero");

    a_read_on_state: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.rdStb && busReq.addr == CCIE_OFF_ENABLE && enableState[0] |=>
        busRsp.rdData[1:0] == CCIE_STATE_ON)
        else $error("enabled channel one reads wrong");

    a_read_off_state: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.rdStb && busReq.addr == CCIE_OFF_ENABLE && !enableState[3] |=>
        busRsp.rdData[7:6] == CCIE_STATE_OFF)
        else $error("disabled channel four reads wrong");

    a_pending_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.rdStb && busReq.addr == CCIE_OFF_PENDING |=> busRsp.rdData[7:4] == 4'h0)
        else $error("pending reserved bits not zero");

    a_irq_needs_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hostIrq |-> $past(enableState) != 4'h0)
        else $error("host interrupt with no channel enabled");

    // a request that stays enabled reaches the line three edges after the pin
    a_irq_latency: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(canIrqPin[0]) ##2 (enableState[0] && irqSync2Reg[0]) |=> hostIrq)
        else $error("channel one request did not reach the line");

    a_reset_quiet: assert property (@(posedge sys_clk)
        $fell(sys_rst) |-> !hostIrq && !busRsp.rdValid && enableState == 4'h0)
        else $error("outputs not quiet after reset");

    c_enable_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit ##1 enableState == 4'hF);
    c_irq_raise: cover property (@(posedge sys_clk) disable iff (sys_rst)
        !hostIrq ##1 hostIrq);
    c_pending_read: cover property (@(posedge sys_clk) disable iff (sys_rst)
        busReq.rdStb && busReq.addr == CCIE_OFF_PENDING && irqSync2Reg != 4'h0);
    c_clear_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
        wrEnableHit && busReq.wrData[1:0] == CCIE_CMD_CLEAR ##1 !enableState[0]);
    c_irq_fall: cover property (@(posedge sys_clk) disable iff (sys_rst)
        hostIrq ##1 !hostIrq);

endmodule

// ===== test/can_channel_irq_enable_tb.sv
// self-checking bench for ccie_top with a host model and random traffic
// assumes the host model launches strobes on the falling edge
`timescale 1ns/1ps
module can_channel_irq_enable_tb;
    import ccie_pkg::*;
    logic          sys_clk   = 1'b0;
    logic          sys_rst   = 1'b1;
    logic [3:0]    canIrqPin = 4'h0;
    ccie_bus_req_t busReq;
    ccie_bus_rsp_t busRsp;
    logic          hostIrq;
    logic [7:0]    expQ[$];
    logic [31:0]   seed      = 32'h6FB02F9E;
    logic [3:0]    enMdl     = 4'h0;
    logic [3:0]    a;
    logic [7:0]    d;
    logic [7:0]    rdExp;
    int            err_total = 0;
    int            n_tests   = 0;

    always #4 sys_clk = ~sys_clk;

    ccie_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .busReq(busReq), .busRsp(busRsp),
                  .canIrqPin(canIrqPin), .hostIrq(hostIrq));
    ccie_host_model host (.sys_clk(sys_clk), .busReq(busReq));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_irq(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [3:0] ra, input logic [7:0] e);
        expQ.push_back(e);
        host.access(1'b0, ra, 8'h00);
    endtask

    task automatic finish_test();
        $display("errors=%0d compares=%0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // read data is settled by the falling edge after the strobe
    always @(negedge sys_clk)
        if (busRsp.rdValid === 1'b1)
            cmp(busRsp.rdData, expQ.size() ? expQ.pop_front() : 8'hXX);

    initial
    begin
        #20000;
        err_total++;
        finish_test();
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        rd(CCIE_OFF_ENABLE, 8'h00);
        for (int i = 0; i < 40; i++)
        begin
            seed = xs(seed);
            d = seed[7:0];
            canIrqPin = seed[11:8];
            // every eighth write aims at the read-only pending offset
            a = (i % 8 == 7) ? CCIE_OFF_PENDING : CCIE_OFF_ENABLE;
            for (int c = 0; c < 4; c++)
                if (a == CCIE_OFF_ENABLE && d[2*c+1])
                    enMdl[c] = d[2*c];
            for (int c = 0; c < 4; c++)
                rdExp[2*c+:2] = enMdl[c] ? CCIE_STATE_ON : CCIE_STATE_OFF;
            host.access(1'b1, a, d);
            rd(CCIE_OFF_ENABLE, rdExp);
            rd(CCIE_OFF_PENDING, {4'h0, canIrqPin});
            rd(4'h3, CCIE_READ_UNMAPPED);
            cmp_irq(hostIrq, |(canIrqPin & enMdl));
        end
        // a mid-run reset must clear every enable and drop the line
        @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        enMdl = 4'h0;
        cmp_irq(hostIrq, 1'b0);
        rd(CCIE_OFF_ENABLE, 8'h00);
        rd(CCIE_OFF_PENDING, {4'h0, canIrqPin});
        cmp_irq(hostIrq, |(canIrqPin & enMdl));
        @(negedge sys_clk);
        finish_test();
    end
endmodule

// ===== test/ccie_host_model.sv
// host bus master model driving the enable block's register port
// assumes strobes are launched and released on the falling edge of sys_clk
`timescale 1ns/1ps
module ccie_host_model
    import ccie_pkg::*;
(
    // clock
    input  wire logic     sys_clk,
    // bus request
    output ccie_bus_req_t busReq
);
    // divider setup is controller bring-up, never a write to this block
    initial busReq = '0;

    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        busReq = '{wrStb: wr, rdStb: !wr, addr: a, wrData: d};
        @(negedge sys_clk);
        // released lines show the inverse so stale values cannot pass
        busReq = '{wrStb: 1'b0, rdStb: 1'b0, addr: ~a, wrData: ~d};
    endtask
endmodule
